// ==== rtl/lisx_top.sv ====
// Lane initialisation start states with APB control and status
//
// Overview of operation
// - Signal-loss state entered only from active
// - Send 32 signal-lost words there
// - After 32 words go to quiet line
// - Full reinit wins everywhere, to full state
// - Soft reinit next, to quiet line
// - Exits tested in fixed priority order
// - Wait to start on lane go
// - Start entry launches 20 us timer
// - Start sends idles, watches control words
// - Start back to wait without go/wake
// - Two idles: start to local-first
// - Two inverted idle/init: to polarity fix
// - Two init words: start to mutual
// - Start timeout goes to quiet line
// - Wait to wake on wake without go
// - Wake state sends no words, examines received ones
// - Wake back to wait without wake/go
// - Wake to start on lane go
// - Two idles: wake to remote-first
// - Two inverted idles: wake polarity fix
// - Polarity states invert rx, 1 us timer
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "lisx_defines.svh"

module lisx_top #(
  parameter int ADDR_W = 12,
  parameter int TMR_W = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_link_clk,
  input wire logic [2:0] rx_code,
  input wire logic rx_no_signal,
  input wire logic to_wait,
  input wire logic to_active,
  output logic [1:0] tx_code,
  output logic tx_word_stb,
  output logic rx_invert,
  output logic [11:0] lane_state
);

  generate
    if (ADDR_W < 3 || ADDR_W > 32) begin : g_bad_addr
      $error("ADDR_W out of range");
    end
    if (`LISX_INIT_TO_CYC >= (1 << TMR_W)) begin : g_bad_tmr
      $error("TMR_W too small for timeouts");
    end
  endgenerate

  // Loaded one short: the exit edge is the last cycle of the timeout
  localparam logic [TMR_W-1:0] INIT_LOAD = TMR_W'(`LISX_INIT_TO_CYC - 1);
  localparam logic [TMR_W-1:0] POL_LOAD = TMR_W'(`LISX_POL_TO_CYC - 1);

  lisx_pkg::lisx_state_t state_r;
  lisx_pkg::lisx_state_t state_nxt;
  lisx_pkg::lisx_ctrl_t ctrl_r;
  lisx_pkg::lisx_status_t status_w;
  lisx_pkg::lisx_rx_t last_cls_r;
  lisx_pkg::lisx_rx_t rx_cls;
  lisx_pkg::lisx_tx_t tx_code_r;
  lisx_pkg::lisx_tx_t tx_nxt;

  logic clk_s1_r;
  logic clk_s2_r;
  logic clk_s3_r;
  logic [2:0] code_s1_r;
  logic [2:0] code_s2_r;
  logic nosig_s1_r;
  logic nosig_s2_r;
  logic [1:0] match_cnt_r;
  logic [5:0] loss_cnt_r;
  logic [TMR_W-1:0] init_cnt_r;
  logic [TMR_W-1:0] pol_cnt_r;
  logic init_run_r;
  logic pol_run_r;
  logic inv_r;
  logic inv_nxt;
  logic [31:0] prdata_r;

  // Link clock and its data are from another domain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_s1_r <= 1'b0;
      clk_s2_r <= 1'b0;
      clk_s3_r <= 1'b0;
      code_s1_r <= 3'h0;
      code_s2_r <= 3'h0;
      nosig_s1_r <= 1'b0;
      nosig_s2_r <= 1'b0;
    end else begin
      clk_s1_r <= rx_link_clk;
      clk_s2_r <= clk_s1_r;
      clk_s3_r <= clk_s2_r;
      code_s1_r <= rx_code;
      code_s2_r <= code_s1_r;
      nosig_s1_r <= rx_no_signal;
      nosig_s2_r <= nosig_s1_r;
    end
  end

  // One word slot per rising edge of the link clock
  wire link_edge = clk_s2_r & ~clk_s3_r;
  wire no_signal = nosig_s2_r;
  assign rx_cls = lisx_pkg::lisx_rx_t'(code_s2_r);

  wire same_cls = (rx_cls == last_cls_r) &&
                  (rx_cls != lisx_pkg::rx_none);
  wire pair_seen = (match_cnt_r == `LISX_MATCH_WORDS);
  wire got_idle = pair_seen && (last_cls_r == lisx_pkg::rx_idle);
  wire got_inv_idle = pair_seen &&
                      (last_cls_r == lisx_pkg::rx_inv_idle);
  wire got_init = pair_seen && (last_cls_r == lisx_pkg::rx_init);
  wire got_inv_init = pair_seen &&
                      (last_cls_r == lisx_pkg::rx_inv_init);
  wire state_change = (state_nxt != state_r);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      match_cnt_r <= 2'h0;
      last_cls_r <= lisx_pkg::rx_none;
    end else if (state_change) begin
      match_cnt_r <= 2'h0;
      last_cls_r <= lisx_pkg::rx_none;
    end else if (link_edge) begin
      last_cls_r <= rx_cls;
      if (rx_cls == lisx_pkg::rx_none) begin
        match_cnt_r <= 2'h0;
      end else if (!same_cls) begin
        match_cnt_r <= 2'h1;
      end else if (!pair_seen) begin
        match_cnt_r <= match_cnt_r + 2'h1;
      end
    end
  end

  wire in_start = (state_r == lisx_pkg::start_state);
  wire in_loss = (state_r == lisx_pkg::signal_loss_notify_state);
  wire nxt_start = (state_nxt == lisx_pkg::start_state);
  wire nxt_pol = (state_nxt == lisx_pkg::polarity_fix_state) ||
                 (state_nxt == lisx_pkg::wake_polarity_fix_state);
  wire nxt_init_zone = nxt_start ||
                       (state_nxt == lisx_pkg::polarity_fix_state);
  wire nxt_clear_inv = (state_nxt == lisx_pkg::idle_wait_state) ||
                       (state_nxt == lisx_pkg::line_quiet_state) ||
                       (state_nxt == lisx_pkg::full_reinit_state);

  wire init_load = nxt_start && !in_start;
  wire init_exp = init_run_r && (init_cnt_r == '0);
  wire pol_load = nxt_pol && state_change;
  wire pol_exp = pol_run_r && (pol_cnt_r == '0);

  // The init timer keeps running through the polarity fix
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      init_cnt_r <= '0;
      init_run_r <= 1'b0;
    end else if (init_load) begin
      init_cnt_r <= INIT_LOAD;
      init_run_r <= 1'b1;
    end else if (!nxt_init_zone) begin
      init_run_r <= 1'b0;
    end else if (init_cnt_r != '0) begin
      init_cnt_r <= init_cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pol_cnt_r <= '0;
      pol_run_r <= 1'b0;
    end else if (pol_load) begin
      pol_cnt_r <= POL_LOAD;
      pol_run_r <= 1'b1;
    end else if (!nxt_pol) begin
      pol_run_r <= 1'b0;
    end else if (pol_cnt_r != '0) begin
      pol_cnt_r <= pol_cnt_r - 1'b1;
    end
  end

  wire loss_done = (loss_cnt_r == `LISX_LOSS_WORDS);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loss_cnt_r <= 6'h00;
    end else if (!in_loss) begin
      loss_cnt_r <= 6'h00;
    end else if (link_edge && !loss_done) begin
      loss_cnt_r <= loss_cnt_r + 6'h01;
    end
  end

  wire go = ctrl_r.lane_go;
  wire wake = ctrl_r.remote_wake_enable;

  always_comb begin
    state_nxt = state_r;
    if (ctrl_r.full_reinit) begin
      state_nxt = lisx_pkg::full_reinit_state;
    end else if (ctrl_r.soft_reinit) begin
      state_nxt = lisx_pkg::line_quiet_state;
    end else begin
      unique case (state_r)
        lisx_pkg::idle_wait_state: begin
          if (go) begin
            state_nxt = lisx_pkg::start_state;
          end else if (wake) begin
            state_nxt = lisx_pkg::remote_wake_state;
          end
        end
        lisx_pkg::start_state: begin
          if (!go && !wake) begin
            state_nxt = lisx_pkg::idle_wait_state;
          end else if (got_idle) begin
            state_nxt = lisx_pkg::local_first_state;
          end else if (got_inv_idle || got_inv_init) begin
            state_nxt = lisx_pkg::polarity_fix_state;
          end else if (got_init) begin
            state_nxt = lisx_pkg::mutual_start_state;
          end else if (init_exp) begin
            state_nxt = lisx_pkg::line_quiet_state;
          end
        end
        lisx_pkg::remote_wake_state: begin
          if (!wake && !go) begin
            state_nxt = lisx_pkg::idle_wait_state;
          end else if (go) begin
            state_nxt = lisx_pkg::start_state;
          end else if (got_idle) begin
            state_nxt = lisx_pkg::remote_first_state;
          end else if (got_inv_idle) begin
            state_nxt = lisx_pkg::wake_polarity_fix_state;
          end
        end
        lisx_pkg::signal_loss_notify_state: begin
          if (loss_done) begin
            state_nxt = lisx_pkg::line_quiet_state;
          end
        end
        lisx_pkg::polarity_fix_state: begin
          if (no_signal) begin
            state_nxt = lisx_pkg::line_quiet_state;
          end else if (got_idle) begin
            state_nxt = lisx_pkg::local_first_state;
          end else if (got_init) begin
            state_nxt = lisx_pkg::mutual_start_state;
          end else if (pol_exp || init_exp) begin
            state_nxt = lisx_pkg::line_quiet_state;
          end
        end
        lisx_pkg::wake_polarity_fix_state: begin
          if (no_signal) begin
            state_nxt = lisx_pkg::line_quiet_state;
          end else if (got_idle) begin
            state_nxt = lisx_pkg::remote_first_state;
          end else if (pol_exp) begin
            state_nxt = lisx_pkg::line_quiet_state;
          end
        end
        lisx_pkg::active_state: begin
          if (no_signal) begin
            state_nxt = lisx_pkg::signal_loss_notify_state;
          end
        end
        lisx_pkg::line_quiet_state,
        lisx_pkg::full_reinit_state: begin
          if (to_wait) begin
            state_nxt = lisx_pkg::idle_wait_state;
          end
        end
        // recovery lives in the outer machine
        lisx_pkg::local_first_state,
        lisx_pkg::remote_first_state,
        lisx_pkg::mutual_start_state: begin
          if (to_active) begin
            state_nxt = lisx_pkg::active_state;
          end
        end
      endcase
    end
  end

  assign tx_nxt =
    (state_nxt == lisx_pkg::start_state) ? lisx_pkg::tx_idle :
    (state_nxt == lisx_pkg::signal_loss_notify_state) ?
      lisx_pkg::tx_lost_signal : lisx_pkg::tx_none;

  assign inv_nxt = nxt_pol ? 1'b1 : (nxt_clear_inv ? 1'b0 : inv_r);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= lisx_pkg::full_reinit_state;
      tx_code_r <= lisx_pkg::tx_none;
      inv_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tx_code_r <= tx_nxt;
      inv_r <= inv_nxt;
    end
  end

  // Register bus: zero wait states, errors on unmapped words
  wire [ADDR_W-1:0] ctrl_addr = ADDR_W'(`LISX_CTRL_OFS);
  wire [ADDR_W-1:0] stat_addr = ADDR_W'(`LISX_STAT_OFS);
  wire hit_ctrl = (paddr == ctrl_addr);
  wire hit_stat = (paddr == stat_addr);
  wire hit = hit_ctrl || hit_stat;
  wire setup_rd = psel && !penable && !pwrite;
  wire ctrl_wr = psel && penable && pwrite && hit_ctrl;

  assign status_w.pad = 18'h00000;
  assign status_w.no_signal = no_signal;
  assign status_w.rx_invert = inv_r;
  assign status_w.state = state_r;

  wire [31:0] rd_mux = hit_ctrl ? {28'h0000000, ctrl_r} :
                       hit_stat ? status_w : 32'h00000000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= `LISX_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_r <= pwdata[3:0];
    end
  end

  // Read data is captured in setup so it stands as a flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_r <= 32'h00000000;
    end else if (setup_rd) begin
      prdata_r <= rd_mux;
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign tx_code = tx_code_r;
  // Slot strobe is one cycle per link edge while a word is due
  assign tx_word_stb = link_edge && (tx_code_r != lisx_pkg::tx_none);
  assign rx_invert = inv_r;
  assign lane_state = state_r;

endmodule

// ==== shared/lisx_defines.svh ====
// Offsets, field positions, reset values and timing counts of the lane start block
`ifndef LISX_DEFINES_SVH
`define LISX_DEFINES_SVH
`define LISX_CLK_MHZ 20
`define LISX_INIT_TO_NS 20000
`define LISX_INIT_TO_CYC ((`LISX_INIT_TO_NS * `LISX_CLK_MHZ + 999) / 1000)
`define LISX_POL_TO_NS 1000
`define LISX_POL_TO_CYC ((`LISX_POL_TO_NS * `LISX_CLK_MHZ + 999) / 1000)
`define LISX_LOSS_WORDS 6'h20
`define LISX_MATCH_WORDS 2'h2
`define LISX_CTRL_OFS 12'h000
`define LISX_STAT_OFS 12'h004
`define LISX_CTRL_GO 0
`define LISX_CTRL_WAKE 1
`define LISX_CTRL_FULL 2
`define LISX_CTRL_SOFT 3
`define LISX_CTRL_RST 4'h0
`define LISX_STAT_STATE_LSB 0
`define LISX_STAT_INV 12
`define LISX_STAT_NOSIG 13
`endif

// ==== shared/lisx_pkg.sv ====
// Types of the lane start block: states, word codes and register layouts
package lisx_pkg;
  typedef enum logic [11:0] {
    idle_wait_state = 12'h001,
    start_state = 12'h002,
    remote_wake_state = 12'h004,
    signal_loss_notify_state = 12'h008,
    line_quiet_state = 12'h010,
    full_reinit_state = 12'h020,
    local_first_state = 12'h040,
    remote_first_state = 12'h080,
    mutual_start_state = 12'h100,
    polarity_fix_state = 12'h200,
    wake_polarity_fix_state = 12'h400,
    active_state = 12'h800
  } lisx_state_t;
  typedef enum logic [2:0] {
    rx_none = 3'h0,
    rx_idle = 3'h1,
    rx_inv_idle = 3'h2,
    rx_init = 3'h3,
    rx_inv_init = 3'h4,
    rx_other = 3'h5
  } lisx_rx_t;
  typedef enum logic [1:0] {
    tx_none = 2'h0,
    tx_idle = 2'h1,
    tx_lost_signal = 2'h2
  } lisx_tx_t;
  typedef struct packed {
    logic soft_reinit;
    logic full_reinit;
    logic remote_wake_enable;
    logic lane_go;
  } lisx_ctrl_t;
  typedef struct packed {
    logic [17:0] pad;
    logic no_signal;
    logic rx_invert;
    logic [11:0] state;
  } lisx_status_t;
endpackage

// ==== verif/lisx_peer.sv ====
// Far-end lane model: link clock and received word class
`timescale 1ns/1ps
module lisx_peer (
  input wire logic en,
  input wire logic [2:0] code,
  output logic link_clk,
  output logic [2:0] word
);
  // Clock stands still between frames; word keeps toggling there
  initial begin
    link_clk = 1'b0;
    word = 3'h0;
    #17;
    forever begin
      if (en) begin
        word = code;
        #200 link_clk = 1'b1;
        #200 link_clk = 1'b0;
      end else begin
        word = ~word;
        #200;
      end
    end
  end
endmodule

// ==== verif/lisx_top_asserts.sv ====
// Concurrent checks on the lane start block ports
`timescale 1ns/1ps
module lisx_top_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pslverr,
  input wire logic [1:0] tx_code,
  input wire logic tx_word_stb,
  input wire logic rx_invert,
  input wire logic [11:0] lane_state
);
  localparam int INIT_CYC = 400;
  localparam int POL_CYC = 20;
  logic [5:0] wd_r;
  logic [9:0] tm_r;
  logic [11:0] st_r;
  wire in_loss = lane_state == 12'h008;
  wire in_pol = lane_state == 12'h200 || lane_state == 12'h400;
  wire same = lane_state == st_r;
  // Dwell counter restarts one cycle after every state change
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= 12'h020;
      tm_r <= 10'h0;
      wd_r <= 6'h0;
    end else begin
      st_r <= lane_state;
      tm_r <= same ? tm_r + 10'h1 : 10'h0;
      wd_r <= !in_loss ? 6'h0 : wd_r + {5'h0, tx_word_stb};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_loss_in;
    in_loss && !$past(in_loss) |-> $past(lane_state) == 12'h800;
  endproperty
  a_loss_in: assert property (p_loss_in)
    else $error("loss state entered from a wrong state");
  property p_loss_cnt; in_loss |-> wd_r <= 6'h20; endproperty
  a_loss_cnt: assert property (p_loss_cnt)
    else $error("too many lost-signal words");
  property p_loss_tx; in_loss && tx_word_stb |-> tx_code == 2'h2; endproperty
  a_loss_tx: assert property (p_loss_tx)
    else $error("wrong word sent in loss state");
  property p_loss_exit; in_loss && wd_r == 6'h20 |-> ##[0:3] !in_loss;
  endproperty
  a_loss_exit: assert property (p_loss_exit)
    else $error("loss state held after all words");
  property p_start_tx;
    lane_state == 12'h002 && tx_word_stb |-> tx_code == 2'h1;
  endproperty
  a_start_tx: assert property (p_start_tx)
    else $error("start state not sending idles");
  property p_start_in; $changed(lane_state) && lane_state == 12'h002
    |-> $past(lane_state) inside {12'h001, 12'h004}; endproperty
  a_start_in: assert property (p_start_in)
    else $error("start entered from a wrong state");
  property p_wake_in; $changed(lane_state) && lane_state == 12'h004
    |-> $past(lane_state) == 12'h001; endproperty
  a_wake_in: assert property (p_wake_in)
    else $error("remote wake entered from a wrong state");
  property p_init_to;
    lane_state == 12'h002 && same |-> tm_r < INIT_CYC - 1;
  endproperty
  a_init_to: assert property (p_init_to)
    else $error("start state outlived its timer");
  property p_pol_to; in_pol && same |-> tm_r < POL_CYC - 1; endproperty
  a_pol_to: assert property (p_pol_to)
    else $error("polarity state outlived its timer");
  property p_pol_inv; in_pol && same |-> rx_invert; endproperty
  a_pol_inv: assert property (p_pol_inv)
    else $error("inversion off in polarity state");
  property p_apb_err; psel && penable
    |-> pslverr == !(paddr == 12'h000 || paddr == 12'h004); endproperty
  a_apb_err: assert property (p_apb_err)
    else $error("error response wrong for this address");
  c_far: cover property (lane_state == 12'h080);
  c_both: cover property (lane_state == 12'h100);
  c_loss: cover property (in_loss && wd_r == 6'h20);
endmodule

// ==== verif/lisx_top_tb.sv ====
// Self-checking bench of the lane start block
`timescale 1ns/1ps
module lisx_top_tb;
  logic clk, rst, psel, penable, pwrite, nosig, tow, toa, en, lk;
  logic pready, pslverr, stb, inv, er;
  logic [11:0] paddr, st;
  logic [31:0] pwdata, prdata, q, seed;
  logic [2:0] cd, rxc;
  logic [1:0] txc;
  logic [2:0] wc [4] = '{3'h1, 3'h2, 3'h4, 3'h3};
  logic [11:0] ws [4] = '{12'h040, 12'h200, 12'h200, 12'h100};
  int error_cnt, tests_run, n, k;
  lisx_top u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_link_clk(lk), .rx_code(rxc),
    .rx_no_signal(nosig), .to_wait(tow), .to_active(toa), .tx_code(txc),
    .tx_word_stb(stb), .rx_invert(inv), .lane_state(st));
  lisx_peer u_peer (.en(en), .code(cd), .link_clk(lk), .word(rxc));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tmo();
    error_cnt++;
    summarize();
  endtask
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic apb(input logic w, logic [11:0] a, logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) tmo();
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ctl(input logic [3:0] v);
    apb(1'b1, 12'h000, {28'h0, v});
  endtask
  task automatic wst(input logic [11:0] s);
    #1;
    for (int i = 0; i < 300 && st !== s; i++) begin
      @(posedge clk);
      #1;
    end
    if (st !== s) tmo();
    chk(st, s);
  endtask
  // Counts cycles spent in a state, and word strobes meanwhile
  task automatic hold(input logic [11:0] s);
    for (n = 0; n < 2000 && st === s; n++) begin
      if (stb === 1'b1) k++;
      @(posedge clk);
      #1;
    end
    if (n == 2000) tmo();
  endtask
  task automatic send(input logic [2:0] c, input int m);
    #1;
    cd <= c;
    en <= 1'b1;
    repeat (m) @(posedge lk);
    en <= 1'b0;
  endtask
  task automatic pw();
    @(posedge clk);
    tow <= 1'b1;
    @(posedge clk);
    tow <= 1'b0;
  endtask
  task automatic home();
    ctl(4'h8);
    wst(12'h010);
    ctl(4'h0);
    pw();
    wst(12'h001);
  endtask
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, nosig, tow, toa, en} = 7'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    cd = 3'h0;
    seed = 32'hA;
    error_cnt = 0;
    tests_run = 0;
    k = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(st, 12'h020);
    chk(txc, 2'h0);
    chk(inv, 1'b0);
    apb(1'b0, 12'h000, 32'h0);
    chk(q, 32'h0);
    q = xs();
    // Upper control bits are not stored
    apb(1'b1, 12'h000, {q[31:4], 4'h0});
    apb(1'b0, 12'h000, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk(er, 1'b1);
    chk(q, 32'h0);
    pw();
    wst(12'h001);
    apb(1'b0, 12'h004, 32'h0);
    chk(q, 32'h1);
    chk(er, 1'b0);
    ctl(4'h2);
    wst(12'h004);
    send(3'h1, 2);
    wst(12'h080);
    home();
    ctl(4'h2);
    wst(12'h004);
    chk(txc, 2'h0);
    send(3'h2, 2);
    wst(12'h400);
    hold(12'h400);
    chk(n, 20);
    home();
    ctl(4'h2);
    wst(12'h004);
    ctl(4'h3);
    wst(12'h002);
    chk(txc, 2'h1);
    ctl(4'h0);
    wst(12'h001);
    ctl(4'h2);
    wst(12'h004);
    ctl(4'h0);
    wst(12'h001);
    for (int i = 0; i < 4; i++) begin
      ctl(4'h1);
      wst(12'h002);
      send(wc[i], 2);
      wst(ws[i]);
      @(posedge clk);
      #1;
      chk(inv, ws[i] == 12'h200);
      home();
    end
    ctl(4'h1);
    wst(12'h002);
    send(3'h1, 1);
    send(3'h5, 1);
    send(3'h1, 1);
    repeat (6) @(posedge clk);
    chk(st, 12'h002);
    send(3'h1, 1);
    wst(12'h040);
    @(posedge clk);
    toa <= 1'b1;
    @(posedge clk);
    toa <= 1'b0;
    wst(12'h800);
    nosig <= 1'b1;
    cd <= 3'h0;
    en <= 1'b1;
    k = 0;
    wst(12'h008);
    hold(12'h008);
    en <= 1'b0;
    chk(k, 32);
    chk(st, 12'h010);
    nosig <= 1'b0;
    home();
    ctl(4'h1);
    wst(12'h002);
    hold(12'h002);
    chk(n, 400);
    chk(st, 12'h010);
    home();
    ctl(4'h1);
    wst(12'h002);
    ctl(4'hC);
    wst(12'h020);
    ctl(4'h0);
    pw();
    wst(12'h001);
    summarize();
  end
endmodule
bind lisx_top lisx_top_asserts u_chk (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .paddr(paddr), .pslverr(pslverr), .tx_code(tx_code),
  .tx_word_stb(tx_word_stb), .rx_invert(rx_invert), .lane_state(lane_state));
